// ===== include/rgb_sensor_map.svh
`ifndef RGB_SENSOR_MAP_SVH
`define RGB_SENSOR_MAP_SVH

// Register pointer values
`define REG_CONTROL      8'h00
`define REG_MULT_HIGH    8'h01
`define REG_MULT_LOW     8'h02
`define REG_RESULT_FIRST 8'h03
`define REG_RESULT_LAST  8'h0a

// Control register field positions
`define CTL_ADC_RESET    7
`define CTL_STANDBY_REQ  6
`define CTL_STANDBY_MON  5
`define CTL_GAIN_HIGH    3
`define CTL_MODE_MANUAL  2
`define CTL_STEP_MSB     1
`define CTL_STEP_LSB     0

// Values loaded at power-on
`define CONTROL_RESET    8'he4
`define MULT_HIGH_RESET  8'h0c
`define MULT_LOW_RESET   8'h30

// Timing: base integration unit is 87.5 us, power-on wait is 3 ms
`define CLK_MHZ          50
`define BASE_STEP_NS     87500
`define POR_DELAY_MS     3
`define BASE_STEP_CYC    (`BASE_STEP_NS * `CLK_MHZ / 1000)
`define POR_CYC          (`POR_DELAY_MS * 1000 * 1000 * `CLK_MHZ / 1000)

// Unit multipliers per step code in fixed time mode, as shifts
`define STEP_SHIFT_00    5'd0
`define STEP_SHIFT_01    5'd4
`define STEP_SHIFT_10    5'd8
`define STEP_SHIFT_11    5'd11

// Bus address of the sensor
`define DEV_ADDR_DEFAULT 7'h2a

`endif

// ===== include/rgb_sensor_pkg.sv
package rgb_sensor_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_INTEG = 3'b010,
    SEQ_STORE = 3'b100
  } seq_state_t;

  typedef enum logic [10:0] {
    BUS_IDLE   = 11'h001,
    BUS_ADDR   = 11'h002,
    BUS_A_ACK  = 11'h004,
    BUS_A_HOLD = 11'h008,
    BUS_RX     = 11'h010,
    BUS_W_ACK  = 11'h020,
    BUS_W_HOLD = 11'h040,
    BUS_TX     = 11'h080,
    BUS_R_ACK  = 11'h100,
    BUS_R_WAIT = 11'h200,
    BUS_R_NEXT = 11'h400
  } bus_state_t;

endpackage

// ===== verilog/unit_tick_gen.sv
`timescale 1ns/10ps
module unit_tick_gen #(
  parameter int PERIOD = 4375
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // Control and tick
  input  wire logic run,
  output logic      tick
);
  localparam int W = $clog2(PERIOD + 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         tick_next;

  always_comb begin
    cnt_next  = '0;
    tick_next = 1'b0;
    if (run) begin
      if (cnt_reg == W'(PERIOD - 1)) begin
        tick_next = 1'b1;
      end else begin
        cnt_next = W'(cnt_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// ===== verilog/sensor_bus_slave.sv
`timescale 1ns/10ps
module sensor_bus_slave
  import rgb_sensor_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [6:0] dev_addr,
  // Serial pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Byte side
  output logic            wr_valid,
  output logic            wr_first,
  output logic [7:0]      wr_byte,
  output logic            rd_adv,
  input  wire logic [7:0] rd_data
);
  logic       scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  bus_state_t st_reg,     st_next;
  logic [2:0] cnt_reg,    cnt_next;
  logic [7:0] sh_reg,     sh_next;
  logic       oe_n_reg,   oe_n_next;
  logic       rw_reg,     rw_next;
  logic       first_reg,  first_next;
  logic       wv_reg,     wv_next;
  logic       wf_reg,     wf_next;
  logic [7:0] wb_reg,     wb_next;
  logic       adv_reg,    adv_next;
  logic       rise, fall, start_det, stop_det;

  assign rise      = scl_s2 & ~scl_d;
  assign fall      = ~scl_s2 & scl_d;
  assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    oe_n_next  = oe_n_reg;
    rw_next    = rw_reg;
    first_next = first_reg;
    wv_next    = 1'b0;
    wf_next    = wf_reg;
    wb_next    = wb_reg;
    adv_next   = 1'b0;
    if (stop_det) begin
      st_next   = BUS_IDLE;
      oe_n_next = 1'b1;
    end else if (start_det) begin
      st_next    = BUS_ADDR;
      cnt_next   = 3'd0;
      oe_n_next  = 1'b1;
      first_next = 1'b1;
    end else begin
      unique case (st_reg)
        BUS_IDLE: begin
        end
        BUS_ADDR: if (rise) begin
          sh_next  = {sh_reg[6:0], sda_s2};
          cnt_next = 3'(cnt_reg + 3'd1);
          if (cnt_reg == 3'd7) begin
            if (sh_reg[6:0] == dev_addr) begin
              rw_next = sda_s2;
              st_next = BUS_A_ACK;
            end else begin
              st_next = BUS_IDLE;
            end
          end
        end
        BUS_A_ACK: if (fall) begin
          oe_n_next = 1'b0; // R15 R17
          st_next   = BUS_A_HOLD;
        end
        BUS_A_HOLD: if (fall) begin
          cnt_next = 3'd0;
          if (rw_reg) begin
            sh_next   = rd_data; // R17
            oe_n_next = rd_data[7];
            adv_next  = 1'b1;
            st_next   = BUS_TX;
          end else begin
            oe_n_next = 1'b1;
            st_next   = BUS_RX;
          end
        end
        BUS_RX: if (rise) begin
          sh_next  = {sh_reg[6:0], sda_s2};
          cnt_next = 3'(cnt_reg + 3'd1);
          if (cnt_reg == 3'd7) begin
            wv_next = 1'b1;
            wf_next = first_reg;
            wb_next = {sh_reg[6:0], sda_s2};
            st_next = BUS_W_ACK;
          end
        end
        BUS_W_ACK: if (fall) begin
          oe_n_next = 1'b0; // R15
          st_next   = BUS_W_HOLD;
        end
        BUS_W_HOLD: if (fall) begin
          oe_n_next  = 1'b1;
          first_next = 1'b0;
          cnt_next   = 3'd0;
          st_next    = BUS_RX;
        end
        BUS_TX: begin
          if (fall) begin
            sh_next   = {sh_reg[6:0], 1'b0};
            oe_n_next = sh_reg[6];
          end else if (rise) begin
            cnt_next = 3'(cnt_reg + 3'd1);
            if (cnt_reg == 3'd7) st_next = BUS_R_ACK;
          end
        end
        BUS_R_ACK: if (fall) begin
          oe_n_next = 1'b1;
          st_next   = BUS_R_WAIT;
        end
        BUS_R_WAIT: if (rise) begin
          st_next = sda_s2 ? BUS_IDLE : BUS_R_NEXT; // R17
        end
        BUS_R_NEXT: if (fall) begin
          sh_next   = rd_data;
          oe_n_next = rd_data[7];
          adv_next  = 1'b1;
          cnt_next  = 3'd0;
          st_next   = BUS_TX;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
      st_reg    <= BUS_IDLE;
      cnt_reg   <= 3'd0;
      sh_reg    <= 8'h00;
      oe_n_reg  <= 1'b1;
      rw_reg    <= 1'b0;
      first_reg <= 1'b0;
      wv_reg    <= 1'b0;
      wf_reg    <= 1'b0;
      wb_reg    <= 8'h00;
      adv_reg   <= 1'b0;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      oe_n_reg  <= oe_n_next;
      rw_reg    <= rw_next;
      first_reg <= first_next;
      wv_reg    <= wv_next;
      wf_reg    <= wf_next;
      wb_reg    <= wb_next;
      adv_reg   <= adv_next;
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = oe_n_reg;
  assign wr_valid = wv_reg;
  assign wr_first = wf_reg;
  assign wr_byte  = wb_reg;
  assign rd_adv   = adv_reg;
endmodule

// ===== verilog/rgb_sensor_core.sv
// Notes on behaviour
// R1 - Top control bit holds conversion reset, keeps registers
// R2 - Standby request bit halts conversion, keeps registers
// R3 - Read-only monitor bit shows any standby
// R4 - Gain bit selects high or low gain
// R5 - Mode bit picks manual or fixed time
// R6 - Manual mode: one cycle, then automatic standby
// R7 - Fixed mode: cycles repeat without standby
// R8 - Fixed step codes give 87.5us to 179.2ms
// R9 - Manual mode doubles each step base time
// R10 - Manual mode multiplies base by sixteen-bit N
// R11 - Multiplier high byte at 01, low at 02
// R12 - Results at 03..0A, high first, R G B C
// R13 - Results hold until next measurement replaces them
// R14 - Power-on wait about 3 ms, then defaults
// R15 - Control write: address, pointer 00, byte, acks
// R16 - Host starts with reset-set write, then clear
// R17 - Read: pointer 03, restart, eight bytes, NACK last
// R18 - Pointer advances after every data byte
// R19 - Control bit 4 reads zero, ignores writes
`timescale 1ns/10ps
`include "rgb_sensor_map.svh"
module rgb_sensor_core
  import rgb_sensor_pkg::*;
#(
  parameter int         POR_CYCLES  = `POR_CYC,
  parameter int         UNIT_CYCLES = `BASE_STEP_CYC,
  parameter logic [6:0] DEV_ADDR    = `DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Serial bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Photodiode front end
  input  wire logic       photo_pulse,
  output logic [1:0]      chan_sel,
  output logic            gain_high,
  output logic            integrating,
  output logic            standby
);
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  localparam logic [7:0] CTL_DEFAULT = `CONTROL_RESET;

  // Power-on delay
  logic [POR_W-1:0] por_cnt_reg;
  logic [POR_W-1:0] por_cnt_next;
  logic             por_done_reg;
  logic             por_done_next;
  logic             bus_rst;

  // Control and multiplier registers
  logic             adc_rst_reg,  adc_rst_next;
  logic             sb_req_reg,   sb_req_next;
  logic             gain_reg,     gain_next;
  logic             mode_reg,     mode_next;
  logic [1:0]       step_reg,     step_next;
  logic             auto_sb_reg,  auto_sb_next;
  logic [15:0]      mult_reg,     mult_next;
  logic [7:0]       ptr_reg,      ptr_next;
  logic [7:0]       ctl_rdata;
  logic [7:0]       rd_data;
  logic [7:0]       res_off;

  // Sequencer
  seq_state_t       state_reg,    state_next;
  logic [1:0]       chan_reg,     chan_next;
  logic [28:0]      unit_cnt_reg, unit_cnt_next;
  logic [15:0]      photo_reg,    photo_next;
  logic [3:0][15:0] result_reg,   result_next;
  logic [28:0]      target;
  logic             run;
  logic             unit_tick;
  logic             manual_done;

  // Photo pulse synchroniser
  logic             ph_s1, ph_s2, ph_d;
  logic             photo_edge;

  // Output flops
  logic [1:0]       chan_sel_reg,    chan_sel_next;
  logic             gain_high_reg,   gain_high_next;
  logic             integ_reg,       integ_next;
  logic             standby_reg,     standby_next;

  // Bus slave byte side
  logic             wr_valid;
  logic             wr_first;
  logic [7:0]       wr_byte;
  logic             rd_adv;

  // Integration length in base units for the current settings
  function automatic logic [28:0] units_for(input logic manual,
                                            input logic [1:0] step,
                                            input logic [15:0] n);
    logic [4:0]  sh;
    logic [28:0] base;
    sh = `STEP_SHIFT_00;
    unique case (step)
      2'b00: sh = `STEP_SHIFT_00; // R8
      2'b01: sh = `STEP_SHIFT_01;
      2'b10: sh = `STEP_SHIFT_10;
      2'b11: sh = `STEP_SHIFT_11;
    endcase
    base = 29'd1 << sh;
    if (manual) begin // R5
      units_for = 29'((base << 1) * {13'h0000, n}); // R9 R10
    end else begin
      units_for = base; // R8
    end
  endfunction

  assign target     = units_for(mode_reg, step_reg, mult_reg);
  assign run        = ~adc_rst_reg & ~sb_req_reg & ~auto_sb_reg; // R1 R2
  assign photo_edge = ph_s2 & ~ph_d;
  assign bus_rst    = srst | ~por_done_reg;

  // Power-on wait, bus ignored until it ends
  always_comb begin
    por_cnt_next  = por_cnt_reg;
    por_done_next = por_done_reg;
    if (!por_done_reg) begin
      if (por_cnt_reg == POR_W'(POR_CYCLES - 1)) begin
        por_done_next = 1'b1; // R14
      end else begin
        por_cnt_next = POR_W'(por_cnt_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
    end else begin
      por_cnt_reg  <= por_cnt_next;
      por_done_reg <= por_done_next;
    end
  end

  // Control read value, bit 4 always zero
  always_comb begin
    ctl_rdata                   = 8'h00; // R19
    ctl_rdata[`CTL_ADC_RESET]   = adc_rst_reg;
    ctl_rdata[`CTL_STANDBY_REQ] = sb_req_reg;
    ctl_rdata[`CTL_STANDBY_MON] = sb_req_reg | auto_sb_reg; // R3
    ctl_rdata[`CTL_GAIN_HIGH]   = gain_reg;
    ctl_rdata[`CTL_MODE_MANUAL] = mode_reg;
    ctl_rdata[`CTL_STEP_MSB:`CTL_STEP_LSB] = step_reg;
  end

  // Read mux on the pointer
  always_comb begin
    res_off = 8'(ptr_reg - `REG_RESULT_FIRST);
    rd_data = 8'h00;
    if (ptr_reg == `REG_CONTROL) begin
      rd_data = ctl_rdata;
    end else if (ptr_reg == `REG_MULT_HIGH) begin
      rd_data = mult_reg[15:8]; // R11
    end else if (ptr_reg == `REG_MULT_LOW) begin
      rd_data = mult_reg[7:0];
    end else if (ptr_reg >= `REG_RESULT_FIRST &&
                 ptr_reg <= `REG_RESULT_LAST) begin
      rd_data = res_off[0] ? result_reg[res_off[2:1]][7:0]
                           : result_reg[res_off[2:1]][15:8]; // R12
    end
  end

  // Register writes and pointer
  always_comb begin
    adc_rst_next = adc_rst_reg;
    sb_req_next  = sb_req_reg;
    gain_next    = gain_reg;
    mode_next    = mode_reg;
    step_next    = step_reg;
    auto_sb_next = auto_sb_reg;
    mult_next    = mult_reg;
    ptr_next     = ptr_reg;
    if (wr_valid) begin
      if (wr_first) begin
        ptr_next = wr_byte; // R15 R17
      end else begin
        ptr_next = 8'(ptr_reg + 8'h01); // R18
        if (ptr_reg == `REG_CONTROL) begin
          adc_rst_next = wr_byte[`CTL_ADC_RESET]; // R1
          sb_req_next  = wr_byte[`CTL_STANDBY_REQ]; // R2
          gain_next    = wr_byte[`CTL_GAIN_HIGH]; // R4
          mode_next    = wr_byte[`CTL_MODE_MANUAL]; // R5
          step_next    = wr_byte[`CTL_STEP_MSB:`CTL_STEP_LSB];
          auto_sb_next = 1'b0;
        end else if (ptr_reg == `REG_MULT_HIGH) begin
          mult_next[15:8] = wr_byte; // R11
        end else if (ptr_reg == `REG_MULT_LOW) begin
          mult_next[7:0] = wr_byte;
        end
      end
    end else if (rd_adv) begin
      ptr_next = 8'(ptr_reg + 8'h01); // R18
    end
    if (manual_done) begin
      auto_sb_next = 1'b1; // R6
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      adc_rst_reg <= CTL_DEFAULT[`CTL_ADC_RESET]; // R14
      sb_req_reg  <= CTL_DEFAULT[`CTL_STANDBY_REQ];
      gain_reg    <= CTL_DEFAULT[`CTL_GAIN_HIGH];
      mode_reg    <= CTL_DEFAULT[`CTL_MODE_MANUAL];
      step_reg    <= CTL_DEFAULT[`CTL_STEP_MSB:`CTL_STEP_LSB];
      auto_sb_reg <= CTL_DEFAULT[`CTL_STANDBY_MON];
      mult_reg    <= {`MULT_HIGH_RESET, `MULT_LOW_RESET};
      ptr_reg     <= `REG_CONTROL;
    end else begin
      adc_rst_reg <= adc_rst_next;
      sb_req_reg  <= sb_req_next;
      gain_reg    <= gain_next;
      mode_reg    <= mode_next;
      step_reg    <= step_next;
      auto_sb_reg <= auto_sb_next;
      mult_reg    <= mult_next;
      ptr_reg     <= ptr_next;
    end
  end

  // Measurement sequencer: red, green, blue, correction
  always_comb begin
    state_next    = state_reg;
    chan_next     = chan_reg;
    unit_cnt_next = unit_cnt_reg;
    photo_next    = photo_reg;
    result_next   = result_reg; // R13
    manual_done   = 1'b0;
    if (photo_edge && photo_reg != 16'hffff) begin
      photo_next = 16'(photo_reg + 16'h0001);
    end
    unique case (state_reg)
      SEQ_IDLE: begin
        unit_cnt_next = 29'd0;
        photo_next    = 16'h0000;
        chan_next     = 2'd0;
        if (run) state_next = SEQ_INTEG;
      end
      SEQ_INTEG: begin
        if (!run) begin
          state_next = SEQ_IDLE; // R1 R2
        end else if (unit_tick) begin
          if (29'(unit_cnt_reg + 29'd1) >= target) begin
            state_next = SEQ_STORE;
          end else begin
            unit_cnt_next = 29'(unit_cnt_reg + 29'd1);
          end
        end
      end
      SEQ_STORE: begin
        result_next[chan_reg] = photo_reg; // R12 R13
        unit_cnt_next = 29'd0;
        photo_next    = 16'h0000;
        chan_next     = 2'(chan_reg + 2'd1);
        state_next    = SEQ_INTEG;
        if (chan_reg == 2'd3 && mode_reg) begin
          manual_done = 1'b1; // R6
          state_next  = SEQ_IDLE;
        end // R7
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg    <= SEQ_IDLE;
      chan_reg     <= 2'd0;
      unit_cnt_reg <= 29'd0;
      photo_reg    <= 16'h0000;
      result_reg   <= '0;
      ph_s1        <= 1'b0;
      ph_s2        <= 1'b0;
      ph_d         <= 1'b0;
    end else begin
      state_reg    <= state_next;
      chan_reg     <= chan_next;
      unit_cnt_reg <= unit_cnt_next;
      photo_reg    <= photo_next;
      result_reg   <= result_next;
      ph_s1        <= photo_pulse;
      ph_s2        <= ph_s1;
      ph_d         <= ph_s2;
    end
  end

  // Front-end steering outputs
  always_comb begin
    chan_sel_next  = chan_next;
    gain_high_next = gain_next; // R4
    integ_next     = (state_next == SEQ_INTEG);
    standby_next   = sb_req_next | auto_sb_next; // R3
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      chan_sel_reg  <= 2'd0;
      gain_high_reg <= 1'b0;
      integ_reg     <= 1'b0;
      standby_reg   <= 1'b0;
    end else begin
      chan_sel_reg  <= chan_sel_next;
      gain_high_reg <= gain_high_next;
      integ_reg     <= integ_next;
      standby_reg   <= standby_next;
    end
  end

  assign chan_sel    = chan_sel_reg;
  assign gain_high   = gain_high_reg;
  assign integrating = integ_reg;
  assign standby     = standby_reg;

  unit_tick_gen #(
    .PERIOD (UNIT_CYCLES)
  ) u_tick (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (state_reg == SEQ_INTEG),
    .tick    (unit_tick)
  );

  sensor_bus_slave u_bus (
    .sys_clk  (sys_clk),
    .srst     (bus_rst),
    .dev_addr (DEV_ADDR),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe_n (sda_oe_n),
    .wr_valid (wr_valid),
    .wr_first (wr_first),
    .wr_byte  (wr_byte),
    .rd_adv   (rd_adv),
    .rd_data  (rd_data)
  );

  AST_ADC_RST_HALTS: assert property ( // R1
    @(posedge sys_clk) disable iff (srst)
    adc_rst_reg ##1 adc_rst_reg |=> !integrating && $stable(result_reg))
    else $error("conversion ran while held in reset");

  AST_STANDBY_HALTS: assert property ( // R2
    @(posedge sys_clk) disable iff (srst)
    sb_req_reg && state_reg != SEQ_STORE
    |=> !integrating && (standby || !sb_req_reg))
    else $error("conversion ran during standby");

  AST_MONITOR_BIT: assert property ( // R3
    @(posedge sys_clk) disable iff (srst)
    auto_sb_reg && !(wr_valid && !wr_first && ptr_reg == `REG_CONTROL)
    |-> ctl_rdata[`CTL_STANDBY_MON] ##1 standby)
    else $error("standby monitor bit not set");

  AST_MANUAL_AUTO_STANDBY: assert property ( // R6
    @(posedge sys_clk) disable iff (srst)
    state_reg == SEQ_STORE && chan_reg == 2'd3 && mode_reg
    |=> auto_sb_reg && state_reg == SEQ_IDLE && standby)
    else $error("manual cycle did not enter standby");

  AST_FIXED_REPEATS: assert property ( // R7
    @(posedge sys_clk) disable iff (srst)
    state_reg == SEQ_STORE && chan_reg == 2'd3 && !mode_reg
    |=> state_reg == SEQ_INTEG && chan_reg == 2'd0)
    else $error("fixed mode did not restart the cycle");

  AST_FIXED_STEP: assert property ( // R8
    @(posedge sys_clk) disable iff (srst)
    !mode_reg |-> target == (step_reg == 2'b11 ? 29'd2048 :
                             step_reg == 2'b10 ? 29'd256 :
                             step_reg == 2'b01 ? 29'd16 : 29'd1))
    else $error("fixed step length wrong");

  AST_MANUAL_STEP: assert property ( // R9
    @(posedge sys_clk) disable iff (srst)
    mode_reg |-> target == 29'(mult_reg * (step_reg == 2'b11 ? 4096 :
                                           step_reg == 2'b10 ? 512 :
                                           step_reg == 2'b01 ? 32 : 2)))
    else $error("manual step length wrong");

  AST_RESULTS_HOLD: assert property ( // R13
    @(posedge sys_clk) disable iff (srst)
    state_reg != SEQ_STORE |=> $stable(result_reg))
    else $error("result changed without a measurement");

  AST_POINTER_ADVANCE: assert property ( // R18
    @(posedge sys_clk) disable iff (srst)
    (wr_valid && !wr_first) || (rd_adv && !wr_valid)
    |=> ptr_reg == 8'($past(ptr_reg) + 8'h01))
    else $error("pointer did not advance");

  AST_BIT4_ZERO: assert property ( // R19
    @(posedge sys_clk) disable iff (srst)
    wr_valid && !wr_first && ptr_reg == `REG_CONTROL |=> !ctl_rdata[4])
    else $error("control bit 4 not zero");

  AST_POR_SILENT: assert property ( // R14
    @(posedge sys_clk) disable iff (srst)
    !por_done_reg |-> sda_oe_n && mult_reg == 16'h0c30)
    else $error("bus active during power-on wait");
endmodule

// ===== sim/i2c_host.sv
`timescale 1ns/10ps
module i2c_host #(
  parameter int Q = 2
) (
  // Clock
  input  wire logic sys_clk,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe_n
);
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Start or repeated start, leaves SCL low
  task automatic start();
    @(posedge sys_clk);
    sda_oe_n <= 1'b1;
    hold(Q);
    scl <= 1'b1;
    hold(Q);
    sda_oe_n <= 1'b0;
    hold(Q);
    scl <= 1'b0;
    hold(Q);
  endtask
  task automatic stop();
    sda_oe_n <= 1'b0;
    hold(Q);
    scl <= 1'b1;
    hold(Q);
    sda_oe_n <= 1'b1;
    hold(Q);
  endtask
  // Eight bits MSB first, then the acknowledge bit
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_oe_n <= d[i];
      hold(Q);
      scl <= 1'b1;
      hold(Q);
      r[i] = sda;
      hold(Q);
      scl <= 1'b0;
      hold(Q);
    end
  endtask
endmodule

// ===== sim/test_rgb_sensor_register_control.sv
`timescale 1ns/10ps
module test_rgb_sensor_register_control;
  localparam int UNIT = 4;
  logic       sys_clk;
  logic       srst;
  logic       photo_pulse;
  logic [1:0] chan_sel;
  logic       gain_high;
  logic       integrating;
  logic       standby;
  logic       scl;
  logic       host_oe_n;
  logic       sda_oe_n;
  logic       dev_sda;
  wire logic  sda = host_oe_n & (sda_oe_n | dev_sda);
  int         fails = 0;
  int         comparisons = 0;
  int         pcnt = 0;
  int         u [4] = '{1, 16, 256, 2048};
  logic [7:0] rb [0:7];
  logic [8:0] rx;

  rgb_sensor_core #(.POR_CYCLES(20), .UNIT_CYCLES(UNIT)) uut (
    .sys_clk(sys_clk), .srst(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(dev_sda), .sda_oe_n(sda_oe_n), .photo_pulse(photo_pulse),
    .chan_sel(chan_sel), .gain_high(gain_high),
    .integrating(integrating), .standby(standby));
  i2c_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl),
    .sda_oe_n(host_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Light differs per channel: a rising edge every 8, 12, 16, 20 cycles
  always @(posedge sys_clk) begin
    pcnt <= pcnt + 1;
    if (pcnt >= 3 + 2 * chan_sel) begin
      pcnt <= 0;
      photo_pulse <= ~photo_pulse;
    end
  end

  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] v, input int lo, input int hi,
                     input string m);
    comparisons++;
    if ((v >= lo && v <= hi) !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t %s got %h", $time, m, v);
    end
  endtask
  task automatic put(input logic [7:0] d);
    host.xfer({d, 1'b1}, rx);
    chk(rx[0], 0, 0, "ack");
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
    host.start();
    put(8'h54);
    put(p);
    for (int i = n - 1; i >= 0; i--) put(d[8*i +: 8]);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    host.start();
    put(8'h54);
    put(p);
    host.start();
    put(8'h55);
    for (int i = 0; i < n; i++) begin
      host.xfer({8'hff, i == n - 1}, rx);
      rb[i] = rx[8:1];
    end
    host.stop();
  endtask
  task automatic wait_chan(input logic [1:0] c, output int n);
    n = 0;
    while (chan_sel !== c && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  task automatic chan_len(input int cyc);
    int n;
    wait_chan(2'd1, n);
    wait_chan(2'd2, n);
    chk(n, cyc, cyc + 8, "channel time");
  endtask
  task automatic res(input int cyc);
    for (int k = 0; k < 4; k++) begin
      int e = cyc / (8 + 4 * k);
      chk({rb[2*k], rb[2*k+1]}, e - 1, e + 2, "result");
    end
  endtask

  task automatic t_defaults();
    chk(standby, 1, 1, "standby after power-on");
    rd(8'h00, 4);
    chk(rb[0], 8'he4, 8'he4, "control default");
    chk({rb[1], rb[2]}, 16'h0c30, 16'h0c30, "mult default");
    chk(rb[3], 0, 0, "red default");
  endtask
  task automatic t_regs();
    wr(8'h01, 16'h0010, 2);
    wr(8'h00, 16'h00d4, 1);
    wr(8'h03, 16'h00aa, 1);
    rd(8'h00, 4);
    chk(rb[0], 8'he4, 8'he4, "control bits 5 4");
    chk({rb[1], rb[2]}, 16'h0010, 16'h0010, "multiplier");
    chk(rb[3], 0, 0, "result read-only");
    rd(8'h0b, 1);
    chk(rb[0], 0, 0, "unmapped read");
  endtask
  task automatic t_manual();
    int n;
    wr(8'h00, 16'h0084, 1);
    chk({standby, integrating}, 0, 0, "held in reset");
    wr(8'h00, 16'h0004, 1);
    chk({standby, integrating, gain_high}, 2, 2, "run low gain");
    chan_len(2 * 16 * UNIT);
    n = 0;
    while (standby !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(standby, 1, 1, "auto standby");
    rd(8'h00, 1);
    chk(rb[0], 8'h24, 8'h24, "monitor bit");
    rd(8'h03, 8);
    res(2 * 16 * UNIT);
    rd(8'h03, 8);
    res(2 * 16 * UNIT);
  endtask
  task automatic t_fixed();
    int sb;
    for (int c = 3; c >= 1; c--) begin
      wr(8'h00, 16'(16'h0088 | c), 1);
      wr(8'h00, 16'(16'h0008 | c), 1);
      chk(gain_high, 1, 1, "high gain");
      chan_len(u[c] * UNIT);
    end
    sb = 0;
    for (int i = 0; i < 600; i++) begin
      @(negedge sys_clk);
      sb += (standby !== 1'b0);
    end
    chk(sb, 0, 0, "no standby in fixed mode");
    rd(8'h03, 8);
    res(16 * UNIT);
    wr(8'h00, 16'h00c9, 1);
    chk({standby, integrating}, 2, 2, "standby request");
    wr(8'h00, 16'h0089, 1);
    chk({standby, integrating}, 0, 0, "adc reset");
    rd(8'h01, 2);
    chk({rb[0], rb[1]}, 16'h0010, 16'h0010, "regs kept");
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    final_report();
  end
  initial begin
    srst = 1'b1;
    photo_pulse = 1'b0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (40) @(posedge sys_clk);
    t_defaults();
    t_regs();
    t_manual();
    t_fixed();
    final_report();
  end
endmodule
